// [hdl/lcr_pkg.sv]
// constants for the regulator-seven and charger register bank
// assumes an 8-bit register port with 8-bit offsets
package lcr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SYNC_N = 7;
  localparam int unsigned GRP_N = 4;

  // ----------------------------------------------------------------
  // offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LDO6_CTRL = 8'h61;
  localparam logic [7:0] OFS_LDO7_VSEL = 8'h64;
  localparam logic [7:0] OFS_LDO7_CTRL = 8'h65;
  localparam logic [7:0] OFS_CHG_RSVD = 8'h70;
  localparam logic [7:0] OFS_CHG_CFG = 8'h71;
  localparam logic [7:0] OFS_CHG_STAT = 8'h78;
  localparam logic [7:0] OFS_CHG_IRQEN = 8'h79;

  // ----------------------------------------------------------------
  // ldo7 control fields
  // ----------------------------------------------------------------
  localparam int unsigned VSEL_LSB = 0;
  localparam int unsigned VSEL_W = 6;
  localparam int unsigned CTL_ON = 7;
  localparam int unsigned CTL_DRAIN = 6;
  localparam int unsigned CTL_LOWQ = 5;
  localparam int unsigned CTL_DLY_LSB = 2;
  localparam int unsigned CTL_DLY_W = 3;
  localparam int unsigned CTL_FLT = 1;
  localparam int unsigned CTL_PGOOD = 0;

  // ----------------------------------------------------------------
  // charger config fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_SUSP = 7;
  localparam int unsigned CFG_TOT_LSB = 4;
  localparam int unsigned CFG_PRE_LSB = 2;
  localparam int unsigned CFG_OVP_LSB = 0;
  localparam int unsigned SEL_W = 2;

  // ----------------------------------------------------------------
  // charger status and enable fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_GRP_LSB = 4;
  localparam int unsigned ST_TIMER = 3;
  localparam int unsigned ST_TEMP = 2;
  localparam int unsigned ST_INPUT = 1;
  localparam int unsigned ST_EOC = 0;
  localparam int unsigned EN_TOT = 7;
  localparam int unsigned EN_TEMP_IN = 6;
  localparam int unsigned EN_IN_VALID = 5;
  localparam int unsigned EN_EOC_IN = 4;
  localparam int unsigned EN_PRE = 3;
  localparam int unsigned EN_TEMP_OUT = 2;
  localparam int unsigned EN_IN_LOST = 1;
  localparam int unsigned EN_EOC_OUT = 0;

  // group index inside the four pending flags
  localparam int unsigned G_EOC = 0;
  localparam int unsigned G_INPUT = 1;
  localparam int unsigned G_TEMP = 2;
  localparam int unsigned G_TIMER = 3;

  // synchroniser lane index
  localparam int unsigned S_PG6 = 0;
  localparam int unsigned S_PG7 = 1;
  localparam int unsigned S_FLT7 = 2;
  localparam int unsigned S_PRE = 3;
  localparam int unsigned S_TOT = 4;
  localparam int unsigned S_TEMP = 5;
  localparam int unsigned S_EOC = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

endpackage : lcr_pkg

// [hdl/lcr_regs.sv]
// register bank for linear regulator seven, the regulator-six good flag
// and the battery charger unit configuration and interrupt status
// assumes a plain register port on sys_clk_i; analog flags arrive unsynchronised
`timescale 1ns/1ps

module lcr_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [lcr_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [lcr_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [lcr_pkg::DATA_W-1:0] reg_rdata_o,
  // analog status, asynchronous
  input wire logic ldo6_pgood_i,
  input wire logic ldo7_pgood_i,
  input wire logic ldo7_fault_i,
  input wire logic precharge_timeout_i,
  input wire logic total_timeout_i,
  input wire logic battery_temp_ok_i,
  input wire logic charger_supply_valid_i,
  input wire logic charge_done_i,
  // regulator seven controls
  output logic [lcr_pkg::VSEL_W-1:0] output_voltage_code_o,
  output logic ldo7_enable_o,
  output logic output_drain_enable_o,
  output logic low_quiescent_mode_o,
  output logic [lcr_pkg::CTL_DLY_W-1:0] ldo7_turn_on_delay_o,
  // charger controls
  output logic charge_suspend_o,
  output logic [lcr_pkg::SEL_W-1:0] total_timeout_sel_o,
  output logic [lcr_pkg::SEL_W-1:0] precondition_timeout_sel_o,
  output logic [lcr_pkg::SEL_W-1:0] input_overvoltage_threshold_sel_o,
  // interrupt request, active high level
  output logic irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [lcr_pkg::SYNC_N-1:0] sy1;
    logic [lcr_pkg::SYNC_N-1:0] sy2;
    logic [lcr_pkg::SYNC_N-1:0] sy3;
    logic in1;
    logic in2;
    logic in3;
    logic [7:0] vsel;
    logic [7:0] ctl;
    logic [7:0] rsvd;
    logic [7:0] cfg;
    logic [lcr_pkg::GRP_N-1:0] arm;
    logic [lcr_pkg::GRP_N-1:0] pend;
    logic [7:0] irqen;
    logic [7:0] rdata;
    logic irq;
  } lcr_state_s;

  lcr_state_s st;
  lcr_state_s next_st;
  logic rst_m;
  logic rst_n;
  logic [lcr_pkg::SYNC_N-1:0] raw;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  assign raw = {charge_done_i, battery_temp_ok_i, total_timeout_i, precharge_timeout_i,
                ldo7_fault_i, ldo7_pgood_i, ldo6_pgood_i};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic valid;
    logic tmo;
    logic [lcr_pkg::GRP_N-1:0] ev;
    logic [7:0] stat;
    logic hit_stat_rd;
    valid = 1'b0;
    tmo = 1'b0;
    ev = '0;
    stat = lcr_pkg::READ_ZERO;
    hit_stat_rd = 1'b0;
    next_st = st;

    // two-stage synchronisers, third stage for edges
    next_st.sy1 = raw;
    next_st.sy2 = st.sy1;
    next_st.sy3 = st.sy2;
    next_st.in1 = charger_supply_valid_i;
    next_st.in2 = st.in1;
    next_st.in3 = st.in2;

    // timer, temperature and end-of-charge events count only while input is valid
    valid = st.in2;
    tmo = st.sy2[lcr_pkg::S_PRE] | st.sy2[lcr_pkg::S_TOT];

    ev[lcr_pkg::G_TIMER] = valid &
      ((st.irqen[lcr_pkg::EN_PRE] & st.sy2[lcr_pkg::S_PRE] & ~st.sy3[lcr_pkg::S_PRE]) |
       (st.irqen[lcr_pkg::EN_TOT] & st.sy2[lcr_pkg::S_TOT] & ~st.sy3[lcr_pkg::S_TOT]));
    ev[lcr_pkg::G_TEMP] = valid &
      ((st.irqen[lcr_pkg::EN_TEMP_IN] & st.sy2[lcr_pkg::S_TEMP] & ~st.sy3[lcr_pkg::S_TEMP]) |
       (st.irqen[lcr_pkg::EN_TEMP_OUT] & ~st.sy2[lcr_pkg::S_TEMP] & st.sy3[lcr_pkg::S_TEMP]));
    ev[lcr_pkg::G_INPUT] =
      (st.irqen[lcr_pkg::EN_IN_VALID] & st.in2 & ~st.in3) |
      (st.irqen[lcr_pkg::EN_IN_LOST] & ~st.in2 & st.in3);
    ev[lcr_pkg::G_EOC] = valid &
      ((st.irqen[lcr_pkg::EN_EOC_IN] & st.sy2[lcr_pkg::S_EOC] & ~st.sy3[lcr_pkg::S_EOC]) |
       (st.irqen[lcr_pkg::EN_EOC_OUT] & ~st.sy2[lcr_pkg::S_EOC] & st.sy3[lcr_pkg::S_EOC]));

    // status byte view
    stat[lcr_pkg::ST_GRP_LSB +: lcr_pkg::GRP_N] = st.pend;
    stat[lcr_pkg::ST_TIMER] = valid & tmo;
    stat[lcr_pkg::ST_TEMP] = valid & st.sy2[lcr_pkg::S_TEMP];
    stat[lcr_pkg::ST_INPUT] = st.in2;
    stat[lcr_pkg::ST_EOC] = valid & st.sy2[lcr_pkg::S_EOC];

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        lcr_pkg::OFS_LDO7_VSEL: begin
          next_st.vsel = {2'b00, reg_wdata_i[lcr_pkg::VSEL_LSB +: lcr_pkg::VSEL_W]};
        end
        lcr_pkg::OFS_LDO7_CTRL: begin
          next_st.ctl = {reg_wdata_i[7:1], 1'b0};
        end
        lcr_pkg::OFS_CHG_RSVD: begin
          next_st.rsvd = reg_wdata_i;
        end
        lcr_pkg::OFS_CHG_CFG: begin
          next_st.cfg = reg_wdata_i;
        end
        lcr_pkg::OFS_CHG_STAT: begin
          next_st.arm = reg_wdata_i[lcr_pkg::ST_GRP_LSB +: lcr_pkg::GRP_N];
        end
        lcr_pkg::OFS_CHG_IRQEN: begin
          next_st.irqen = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the following cycle
    next_st.rdata = lcr_pkg::READ_ZERO;
    if (reg_rd_i) begin
      case (reg_addr_i)
        lcr_pkg::OFS_LDO6_CTRL: begin
          next_st.rdata[lcr_pkg::CTL_PGOOD] = st.sy2[lcr_pkg::S_PG6];
        end
        lcr_pkg::OFS_LDO7_VSEL: begin
          next_st.rdata = st.vsel;
        end
        lcr_pkg::OFS_LDO7_CTRL: begin
          next_st.rdata = {st.ctl[7:1], st.sy2[lcr_pkg::S_PG7]};
        end
        lcr_pkg::OFS_CHG_RSVD: begin
          next_st.rdata = st.rsvd;
        end
        lcr_pkg::OFS_CHG_CFG: begin
          next_st.rdata = st.cfg;
        end
        lcr_pkg::OFS_CHG_STAT: begin
          next_st.rdata = stat;
          hit_stat_rd = 1'b1;
        end
        lcr_pkg::OFS_CHG_IRQEN: begin
          next_st.rdata = st.irqen;
        end
        default: begin
          next_st.rdata = lcr_pkg::READ_ZERO;
        end
      endcase
    end

    // pending flags clear on status read, a new event wins
    if (hit_stat_rd) begin
      next_st.pend = '0;
    end
    next_st.pend = next_st.pend | (ev & st.arm);

    next_st.irq = (|st.pend) |
                  (st.ctl[lcr_pkg::CTL_FLT] & st.sy2[lcr_pkg::S_FLT7]);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = st.rdata;
  assign output_voltage_code_o = st.vsel[lcr_pkg::VSEL_LSB +: lcr_pkg::VSEL_W];
  assign ldo7_enable_o = st.ctl[lcr_pkg::CTL_ON];
  assign output_drain_enable_o = st.ctl[lcr_pkg::CTL_DRAIN];
  assign low_quiescent_mode_o = st.ctl[lcr_pkg::CTL_LOWQ];
  assign ldo7_turn_on_delay_o = st.ctl[lcr_pkg::CTL_DLY_LSB +: lcr_pkg::CTL_DLY_W];
  assign charge_suspend_o = st.cfg[lcr_pkg::CFG_SUSP];
  assign total_timeout_sel_o = st.cfg[lcr_pkg::CFG_TOT_LSB +: lcr_pkg::SEL_W];
  assign precondition_timeout_sel_o = st.cfg[lcr_pkg::CFG_PRE_LSB +: lcr_pkg::SEL_W];
  assign input_overvoltage_threshold_sel_o = st.cfg[lcr_pkg::CFG_OVP_LSB +: lcr_pkg::SEL_W];
  assign irq_o = st.irq;

endmodule : lcr_regs

// [bench/lcr_regs_asserts.sv]
// checker for the regulator-seven and charger register bank
// assumes it is bound to lcr_regs and sees only its ports
`timescale 1ns/1ps
module lcr_regs_chk (
  // clock, reset, register port
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // controls
  input wire logic [5:0] output_voltage_code_o,
  input wire logic ldo7_enable_o,
  input wire logic output_drain_enable_o,
  input wire logic low_quiescent_mode_o,
  input wire logic [2:0] ldo7_turn_on_delay_o,
  input wire logic charge_suspend_o,
  input wire logic [1:0] total_timeout_sel_o,
  input wire logic [1:0] precondition_timeout_sel_o,
  input wire logic [1:0] input_overvoltage_threshold_sel_o
);
  logic w64;
  logic w65;
  logic w71;
  assign w64 = reg_wr_i && reg_addr_i == 8'h64;
  assign w65 = reg_wr_i && reg_addr_i == 8'h65;
  assign w71 = reg_wr_i && reg_addr_i == 8'h71;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_vsel_write: assert property (w64 |=> output_voltage_code_o == $past(reg_wdata_i[5:0]))
    else $error("voltage code not taken");
  a_vsel_rsvd: assert property (reg_rd_i && reg_addr_i == 8'h64 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("voltage byte top bits not zero");
  a_on_write: assert property (w65 |=> ldo7_enable_o == $past(reg_wdata_i[7]))
    else $error("enable not taken");
  a_ctl_hold: assert property (!w65 |=> $stable({ldo7_enable_o, output_drain_enable_o, low_quiescent_mode_o}))
    else $error("control changed without write");
  a_ctl_readback: assert property (reg_rd_i && reg_addr_i == 8'h65 |=>
    reg_rdata_o[7:2] == $past({ldo7_enable_o, output_drain_enable_o, low_quiescent_mode_o, ldo7_turn_on_delay_o}))
    else $error("control readback wrong");
  a_drain_write: assert property (w65 |=> output_drain_enable_o == $past(reg_wdata_i[6]))
    else $error("drain not taken");
  a_lowq_write: assert property (w65 |=> low_quiescent_mode_o == $past(reg_wdata_i[5]))
    else $error("low power mode not taken");
  a_delay_write: assert property (w65 |=> ldo7_turn_on_delay_o == $past(reg_wdata_i[4:2]))
    else $error("delay code not taken");
  a_cfg_write: assert property (w71 |=> {charge_suspend_o, total_timeout_sel_o, precondition_timeout_sel_o,
    input_overvoltage_threshold_sel_o} == {$past(reg_wdata_i[7]), $past(reg_wdata_i[5:0])})
    else $error("charger config not taken");
  c_ctl_write: cover property (w65);
  c_cfg_write: cover property (w71);
  c_stat_read: cover property (reg_rd_i && reg_addr_i == 8'h78);
endmodule : lcr_regs_chk

bind lcr_regs lcr_regs_chk u_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .output_voltage_code_o(output_voltage_code_o), .ldo7_enable_o(ldo7_enable_o),
  .output_drain_enable_o(output_drain_enable_o), .low_quiescent_mode_o(low_quiescent_mode_o),
  .ldo7_turn_on_delay_o(ldo7_turn_on_delay_o), .charge_suspend_o(charge_suspend_o),
  .total_timeout_sel_o(total_timeout_sel_o), .precondition_timeout_sel_o(precondition_timeout_sel_o),
  .input_overvoltage_threshold_sel_o(input_overvoltage_threshold_sel_o));

// [bench/testbench.sv]
// self-checking bench for the regulator-seven and charger register bank
// assumes lcr_regs and its bound checker are compiled alongside
`timescale 1ns/1ps
module testbench;
  logic sys_clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic pg6 = 1'h0, pg7 = 1'h0, flt = 1'h0, pre = 1'h0, tot = 1'h0, temp = 1'h0, sup = 1'h0, done = 1'h0;
  logic [7:0] rdata;
  logic [5:0] vcode;
  logic en, drn, lowq, susp, irq;
  logic [2:0] dly;
  logic [1:0] tsel, psel, osel;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  lcr_regs u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ldo6_pgood_i(pg6), .ldo7_pgood_i(pg7),
    .ldo7_fault_i(flt), .precharge_timeout_i(pre), .total_timeout_i(tot), .battery_temp_ok_i(temp),
    .charger_supply_valid_i(sup), .charge_done_i(done), .output_voltage_code_o(vcode),
    .ldo7_enable_o(en), .output_drain_enable_o(drn), .low_quiescent_mode_o(lowq),
    .ldo7_turn_on_delay_o(dly), .charge_suspend_o(susp), .total_timeout_sel_o(tsel),
    .precondition_timeout_sel_o(psel), .input_overvoltage_threshold_sel_o(osel), .irq_o(irq));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ----
  // bus and compare helpers
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk_i);
    wr <= 1'h0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk_i);
    rd <= 1'h0;
    #1;
    chk(rdata, exp);
  endtask : rd_chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wait_n
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [7:0] al [8] = '{8'h61, 8'h64, 8'h65, 8'h70, 8'h71, 8'h78, 8'h79, 8'h7A};
    for (int i = 0; i < 8; i++) rd_chk(al[i], 8'h00);
    chk({en, drn, lowq, dly, susp, vcode[0]}, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ldo7();
    wr_reg(8'h64, 8'hFF);
    chk(vcode, 8'h3F);
    rd_chk(8'h64, 8'h3F);
    for (int i = 1; i < 8; i++) begin
      wr_reg(8'h65, (8'h01 << i) | 8'h01);
      chk({en, drn, lowq, dly}, (8'h01 << i) >> 2);
      rd_chk(8'h65, 8'h01 << i);
    end
    pg6 <= 1'h1;
    pg7 <= 1'h1;
    wait_n(4);
    wr_reg(8'h61, 8'hFE);
    rd_chk(8'h61, 8'h01);
    rd_chk(8'h65, 8'h81);
    $display("regulator test done");
  endtask : t_ldo7
  task automatic t_chg();
    logic [7:0] vl [4] = '{8'hFF, 8'h55, 8'hAA, 8'h00};
    wr_reg(8'h70, 8'hA5);
    rd_chk(8'h70, 8'hA5);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h71, vl[i]);
      chk({susp, tsel, psel, osel}, {vl[i][7], vl[i][5:0]});
      rd_chk(8'h71, vl[i]);
    end
    wr_reg(8'h79, 8'h5A);
    rd_chk(8'h79, 8'h5A);
    $display("charger config test done");
  endtask : t_chg
  task automatic t_irq();
    wr_reg(8'h79, 8'h00);
    wr_reg(8'h78, 8'hF0);
    sup <= 1'h1;
    wait_n(8);
    chk(irq, 8'h00);
    rd_chk(8'h78, 8'h02);
    wr_reg(8'h79, 8'hFF);
    done <= 1'h1;
    wait_n(8);
    chk(irq, 8'h01);
    rd_chk(8'h78, 8'h13);
    wait_n(3);
    chk(irq, 8'h00);
    tot <= 1'h1;
    wait_n(8);
    chk(irq, 8'h01);
    rd_chk(8'h78, 8'h8B);
    temp <= 1'h1;
    wait_n(8);
    rd_chk(8'h78, 8'h4F);
    sup <= 1'h0;
    wait_n(8);
    rd_chk(8'h78, 8'h20);
    wr_reg(8'h65, 8'h02);
    flt <= 1'h1;
    wait_n(8);
    chk(irq, 8'h01);
    wr_reg(8'h65, 8'h00);
    wait_n(3);
    chk(irq, 8'h00);
    $display("interrupt test done");
  endtask : t_irq
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      test_done();
    end
  end
  initial begin
    wait_n(3);
    rstn_i <= 1'h1;
    wait_n(3);
    t_reset();
    t_ldo7();
    t_chg();
    t_irq();
    test_done();
  end
endmodule : testbench
